// ---- rtl/gq_ctrl_pkg.sv ----
// Function
// RULE1: Request word: favored byte high, source low.
// RULE2: Request stores are favored byte or full word.
// RULE3: Device loads source field on signalling.
// RULE4: Firmware clears every global routing mask first.
// RULE5: Hardware reads masks; software reads and writes.
// RULE6: Per-processor change mask is 32-bit one-hot.
// RULE7: Mask bit is processor number modulo 32.
// RULE8: Enable ORs mask in; disable ANDs complement.
// RULE9: Device routes only to available processors.
// RULE10: Available mask exists from system initialization.
// RULE11: Mask addresses are aligned 32-bit words only.
// RULE12: Write through write address, verify via read.
// RULE13: Matching read means new interrupts use mask.
// RULE14: Matching read means new global interrupts follow.
// RULE15: Device offers separate write and read addresses.
// RULE16: Poll with pauses; tolerate in-flight old interrupts.
// RULE17: Descriptor: count, wtype, wbase, rtype, rbase words.
// RULE18: Access type 0 memory, 1 machine dependent.
// RULE19: Device keeps available mask in checked storage.
// RULE20: Favored byte 0xFF means empty queue.
// RULE21: Mask word at base plus four per 32.
`default_nettype none

package gq_ctrl_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;    // System clock period
  localparam int POLL_PAUSE_NS = 100;  // Least pause between unchanged reads
  // Least time, so round up to whole cycles
  localparam int POLL_PAUSE_CYC = (POLL_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Boot descriptor layout
  // ****************************************
  localparam logic [2:0] DESC_COUNT = 3'h0;  // Processor count at byte 0
  localparam logic [2:0] DESC_WTYPE = 3'h1;  // Write access type at byte 4
  localparam logic [2:0] DESC_WBASE = 3'h2;  // Write base at byte 8
  localparam logic [2:0] DESC_RTYPE = 3'h3;  // Read access type at byte 12
  localparam logic [2:0] DESC_RBASE = 3'h4;  // Read base at byte 16
  localparam logic [31:0] ACCESS_MEMORY = 32'h0;   // Plain memory-mapped
  localparam logic [31:0] ACCESS_MACHINE = 32'h1;  // Machine-dependent method

  // ****************************************
  // Request word and masks
  // ****************************************
  localparam logic [7:0] FAVORED_EMPTY = 8'hFF;  // Empty queue marker
  localparam logic [3:0] BE_FAVORED = 4'h8;      // Most significant byte only
  localparam logic [3:0] BE_FULL = 4'hF;         // All four bytes
  localparam logic [31:0] MASK_NONE = 32'h0;     // No processor available
  localparam logic [31:0] MASK_BIT0 = 32'h1;     // One-hot seed
  localparam logic [7:0] RESET_BYTE = 8'h0;      // Reset value of small counters

  // ****************************************
  // Error codes
  // ****************************************
  localparam logic [1:0] ERR_NONE = 2'h0;     // No error
  localparam logic [1:0] ERR_LAYOUT = 2'h1;   // Unusable access type or base
  localparam logic [1:0] ERR_TIMEOUT = 2'h2;  // Change never showed on read
  localparam logic [1:0] ERR_CPU = 2'h3;      // Processor number out of range

  // Command set
  typedef enum logic [2:0] {
    OP_CPU_ON,
    OP_CPU_OFF,
    OP_REQ_BYTE,
    OP_REQ_FULL,
    OP_REQ_EMPTY
  } op_e;

  // Which mask a processor command changes
  typedef enum logic {
    TGT_AVAIL,
    TGT_GLOBAL
  } target_e;

endpackage : gq_ctrl_pkg

`default_nettype wire

// ---- rtl/rmw_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Read-modify-write helper signals between controller and mask unit
interface rmw_if #(
  parameter int CPU_W = 8
);
  logic [CPU_W-1:0] cpu;  // Processor number
  logic [31:0] wbase;     // Write base of mask words
  logic [31:0] rbase;     // Read base of mask words
  logic [31:0] old_word;  // Word read back
  logic turn_on;          // Enable or disable
  logic [31:0] waddr;     // Word write address
  logic [31:0] raddr;     // Word read address
  logic [31:0] mask;      // One-hot processor mask
  logic [31:0] new_word;  // Merged word

  modport calc (
    input cpu, wbase, rbase, old_word, turn_on,
    output waddr, raddr, mask, new_word
  );
  modport user (
    output cpu, wbase, rbase, old_word, turn_on,
    input waddr, raddr, mask, new_word
  );
endinterface : rmw_if

`default_nettype wire

// ---- rtl/mask_unit.sv ----
`timescale 1ns/1ps
`default_nettype none

// Builds the processor mask, its word address and the merged word
module mask_unit #(
  parameter int CPU_W = 8
) (
  rmw_if.calc port
);

  logic [31:0] ofs;  // Byte offset of the processor's word

  // ****************************************
  // Address, mask and merge
  // ****************************************
  always_comb
  begin
    // RULE21: four bytes per 32
    ofs = {{(32 - CPU_W + 3){1'b0}}, port.cpu[CPU_W-1:5], 2'b00};
    port.waddr = port.wbase + ofs;
    port.raddr = port.rbase + ofs;
    // RULE7: modulo 32 select
    // RULE6: single bit set
    port.mask = gq_ctrl_pkg::MASK_BIT0 << port.cpu[4:0];
    // RULE8: OR in or AND out
    if (port.turn_on)
    begin
      port.new_word = port.old_word | port.mask;
    end
    else
    begin
      port.new_word = port.old_word & ~port.mask;
    end
  end

endmodule : mask_unit

`default_nettype wire

// ---- rtl/gq_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

// Host controller for routing masks and the global queue request word
module gq_ctrl #(
  parameter int CPU_W = 8,       // Processor number width
  parameter int MAX_POLLS = 64   // Reads before giving up on a change
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [31:0] desc_addr_i,
  input wire logic [31:0] gq_wbase_i,
  input wire logic [31:0] gq_rbase_i,
  input wire logic [31:0] gq_req_addr_i,
  input wire logic cmd_valid_i,
  input wire gq_ctrl_pkg::op_e cmd_op_i,
  input wire gq_ctrl_pkg::target_e cmd_target_i,
  input wire logic [CPU_W-1:0] cmd_cpu_i,
  input wire logic [31:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic error_o,
  output logic [1:0] error_code_o,
  output logic [31:0] result_o,
  output logic [31:0] bus_addr_o,
  output logic bus_rd_o,
  output logic bus_wr_o,
  output logic [3:0] bus_be_o,
  output logic [31:0] bus_wdata_o,
  input wire logic [31:0] bus_rdata_i,
  input wire logic bus_ack_i
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (CPU_W < 5 || CPU_W > 16)
  begin : g_bad_cpu_w
    $error("CPU_W must be 5 to 16");
  end
  if (MAX_POLLS < 1 || MAX_POLLS > 256)
  begin : g_bad_polls
    $error("MAX_POLLS must be 1 to 256");
  end
  if (gq_ctrl_pkg::POLL_PAUSE_CYC < 1 || gq_ctrl_pkg::POLL_PAUSE_CYC > 256)
  begin : g_bad_pause
    $error("pause count out of range");
  end

  localparam logic [7:0] LAST_POLL = 8'(MAX_POLLS - 1);
  localparam logic [7:0] PAUSE_LAST = 8'(gq_ctrl_pkg::POLL_PAUSE_CYC - 1);
  localparam logic [CPU_W:0] CPU_STEP = (CPU_W + 1)'(32);

  // Controller states
  typedef enum logic [2:0] {
    S_DESC,
    S_INIT,
    S_IDLE,
    S_REQ,
    S_RD_OLD,
    S_WR_NEW,
    S_POLL,
    S_GAP
  } state_e;

  // All controller state
  typedef struct packed {
    state_e st;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic rd;
    logic wr;
    logic [2:0] didx;
    logic bad;
    logic [31:0] nproc;
    logic [31:0] wbase;
    logic [31:0] rbase;
    gq_ctrl_pkg::op_e op;
    logic tgt;
    logic [CPU_W-1:0] cpu;
    logic [31:0] expect_word;
    logic [7:0] polls;
    logic [7:0] gap;
    logic ready;
    logic done;
    logic err;
    logic [1:0] code;
    logic [31:0] result;
  } state_s;

  state_s s_reg;   // Registered state
  state_s s_next;  // Next state
  logic [CPU_W:0] cpu_up;  // Next word's first processor during clearing
  logic cpu_ok;            // Commanded processor exists
  logic layout_ok;         // Bases of chosen mask are word aligned

  rmw_if #(.CPU_W(CPU_W)) rmw ();

  mask_unit #(.CPU_W(CPU_W)) u_mask (
    .port(rmw.calc)
  );

  // ****************************************
  // Mask unit feed
  // ****************************************
  assign rmw.cpu = s_reg.cpu;
  assign rmw.wbase = s_reg.tgt ? gq_wbase_i : s_reg.wbase;
  assign rmw.rbase = s_reg.tgt ? gq_rbase_i : s_reg.rbase;
  assign rmw.old_word = bus_rdata_i;
  assign rmw.turn_on = (s_reg.op == gq_ctrl_pkg::OP_CPU_ON);
  assign cpu_up = {1'b0, s_reg.cpu} + CPU_STEP;
  assign cpu_ok = ({{(32 - CPU_W){1'b0}}, cmd_cpu_i} < s_reg.nproc);
  // RULE11: aligned words only
  assign layout_ok = (cmd_target_i == gq_ctrl_pkg::TGT_GLOBAL)
                     ? (gq_wbase_i[1:0] == 2'b00 && gq_rbase_i[1:0] == 2'b00) : 1'b1;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.err = 1'b0;
    unique case (s_reg.st)
      // Fetch the five descriptor words
      S_DESC:
      begin
        if (!s_reg.rd)
        begin
          // RULE17: word at index times four
          s_next.addr = desc_addr_i + {27'h0, s_reg.didx, 2'b00};
          s_next.rd = 1'b1;
        end
        else if (bus_ack_i)
        begin
          s_next.rd = 1'b0;
          s_next.didx = s_reg.didx + 3'h1;
          unique case (s_reg.didx)
            gq_ctrl_pkg::DESC_COUNT: s_next.nproc = bus_rdata_i;
            gq_ctrl_pkg::DESC_WBASE:
            begin
              s_next.wbase = bus_rdata_i;
              s_next.bad = s_reg.bad | (bus_rdata_i[1:0] != 2'b00);
            end
            gq_ctrl_pkg::DESC_RBASE:
            begin
              s_next.rbase = bus_rdata_i;
              s_next.bad = s_reg.bad | (bus_rdata_i[1:0] != 2'b00);
            end
            // RULE18: only memory access usable
            default: s_next.bad = s_reg.bad | (bus_rdata_i != gq_ctrl_pkg::ACCESS_MEMORY);
          endcase
          if (s_reg.didx == gq_ctrl_pkg::DESC_RBASE)
          begin
            s_next.tgt = gq_ctrl_pkg::TGT_GLOBAL;
            s_next.cpu = '0;
            s_next.st = S_INIT;
          end
        end
      end
      // Clear every global mask word in range
      S_INIT:
      begin
        if (s_reg.bad)
        begin
          // Unusable layout: report once and stay out of service
          s_next.err = !s_reg.err && (s_reg.code == gq_ctrl_pkg::ERR_NONE);
          s_next.code = gq_ctrl_pkg::ERR_LAYOUT;
        end
        else if (s_reg.nproc == gq_ctrl_pkg::MASK_NONE)
        begin
          s_next.st = S_IDLE;
        end
        else if (!s_reg.wr)
        begin
          // RULE4: no processor available
          s_next.addr = rmw.waddr;
          s_next.wdata = gq_ctrl_pkg::MASK_NONE;
          s_next.be = gq_ctrl_pkg::BE_FULL;
          s_next.wr = 1'b1;
        end
        else if (bus_ack_i)
        begin
          s_next.wr = 1'b0;
          s_next.cpu = cpu_up[CPU_W-1:0];
          if (cpu_up[CPU_W] || {{(31 - CPU_W){1'b0}}, cpu_up} >= s_reg.nproc)
          begin
            s_next.st = S_IDLE;
          end
        end
      end
      // Take one command
      S_IDLE:
      begin
        if (cmd_valid_i)
        begin
          s_next.op = cmd_op_i;
          s_next.tgt = cmd_target_i;
          s_next.cpu = cmd_cpu_i;
          s_next.code = gq_ctrl_pkg::ERR_NONE;
          if (cmd_op_i == gq_ctrl_pkg::OP_CPU_ON || cmd_op_i == gq_ctrl_pkg::OP_CPU_OFF)
          begin
            if (!cpu_ok)
            begin
              s_next.err = 1'b1;
              s_next.code = gq_ctrl_pkg::ERR_CPU;
            end
            else if (!layout_ok)
            begin
              s_next.err = 1'b1;
              s_next.code = gq_ctrl_pkg::ERR_LAYOUT;
            end
            else
            begin
              s_next.st = S_RD_OLD;
            end
          end
          else
          begin
            // RULE2: byte or full store
            s_next.addr = gq_req_addr_i;
            s_next.wr = 1'b1;
            s_next.st = S_REQ;
            // RULE1: favored byte on top
            if (cmd_op_i == gq_ctrl_pkg::OP_REQ_FULL)
            begin
              s_next.be = gq_ctrl_pkg::BE_FULL;
              s_next.wdata = cmd_data_i;
            end
            else if (cmd_op_i == gq_ctrl_pkg::OP_REQ_BYTE)
            begin
              s_next.be = gq_ctrl_pkg::BE_FAVORED;
              s_next.wdata = {cmd_data_i[7:0], 24'h0};
            end
            else
            begin
              // RULE20: 0xFF empties queue
              s_next.be = gq_ctrl_pkg::BE_FAVORED;
              s_next.wdata = {gq_ctrl_pkg::FAVORED_EMPTY, 24'h0};
            end
          end
        end
      end
      // Single request store
      S_REQ:
      begin
        if (bus_ack_i)
        begin
          s_next.wr = 1'b0;
          s_next.done = 1'b1;
          s_next.st = S_IDLE;
        end
      end
      // Read the current mask word
      S_RD_OLD:
      begin
        if (!s_reg.rd)
        begin
          // RULE5: only read side read
          s_next.addr = rmw.raddr;
          s_next.rd = 1'b1;
        end
        else if (bus_ack_i)
        begin
          // RULE8: merged word written back
          s_next.rd = 1'b0;
          s_next.wdata = rmw.new_word;
          s_next.expect_word = rmw.new_word;
          s_next.st = S_WR_NEW;
        end
      end
      // Store the merged word
      S_WR_NEW:
      begin
        if (!s_reg.wr)
        begin
          // RULE12: store through write address
          s_next.addr = rmw.waddr;
          s_next.be = gq_ctrl_pkg::BE_FULL;
          s_next.wr = 1'b1;
        end
        else if (bus_ack_i)
        begin
          s_next.wr = 1'b0;
          s_next.polls = gq_ctrl_pkg::RESET_BYTE;
          s_next.st = S_POLL;
        end
      end
      // Read back until the change shows
      S_POLL:
      begin
        if (!s_reg.rd)
        begin
          // RULE12: verify through read address
          s_next.addr = rmw.raddr;
          s_next.rd = 1'b1;
        end
        else if (bus_ack_i)
        begin
          s_next.rd = 1'b0;
          // RULE13: match means mask in force
          // RULE14: same for global masks
          if (bus_rdata_i == s_reg.expect_word)
          begin
            s_next.done = 1'b1;
            s_next.result = bus_rdata_i;
            s_next.st = S_IDLE;
          end
          else if (s_reg.polls == LAST_POLL)
          begin
            s_next.err = 1'b1;
            s_next.code = gq_ctrl_pkg::ERR_TIMEOUT;
            s_next.result = bus_rdata_i;
            s_next.st = S_IDLE;
          end
          else
          begin
            s_next.polls = s_reg.polls + 8'h1;
            s_next.gap = PAUSE_LAST;
            s_next.st = S_GAP;
          end
        end
      end
      // RULE16: pause between unchanged reads
      S_GAP:
      begin
        s_next.gap = s_reg.gap - 8'h1;
        if (s_reg.gap == gq_ctrl_pkg::RESET_BYTE)
        begin
          s_next.st = S_POLL;
        end
      end
    endcase
    s_next.ready = (s_next.st == S_IDLE);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_reg <= '{st: S_DESC, op: gq_ctrl_pkg::OP_CPU_ON, default: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign cmd_ready_o = s_reg.ready;
  assign done_o = s_reg.done;
  assign error_o = s_reg.err;
  assign error_code_o = s_reg.code;
  assign result_o = s_reg.result;
  assign bus_addr_o = s_reg.addr;
  assign bus_rd_o = s_reg.rd;
  assign bus_wr_o = s_reg.wr;
  assign bus_be_o = s_reg.be;
  assign bus_wdata_o = s_reg.wdata;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // RULE2: legal byte lanes
  a_store_lanes: assert property (bus_wr_o |-> // RULE2
    (bus_be_o == gq_ctrl_pkg::BE_FULL || bus_be_o == gq_ctrl_pkg::BE_FAVORED))
    else $error("illegal byte enables on store");
  // RULE11: word aligned accesses
  a_word_aligned: assert property ((bus_rd_o || bus_wr_o) |-> // RULE11
    bus_addr_o[1:0] == 2'b00)
    else $error("unaligned mask access");
  // RULE6: one-hot mask
  a_mask_onehot: assert property ($onehot(rmw.mask)) // RULE6
    else $error("processor mask not one-hot");
  // RULE7: modulo 32 bit
  a_mask_bit: assert property (rmw.mask[s_reg.cpu[4:0]]) // RULE7
    else $error("mask bit does not match processor");
  // RULE8: enable and disable merge
  a_merge_word: assert property ((s_reg.st == S_WR_NEW && bus_wr_o) |-> // RULE8
    ((bus_wdata_o & rmw.mask) == (rmw.turn_on ? rmw.mask : gq_ctrl_pkg::MASK_NONE)))
    else $error("merged word has wrong processor bit");
  // RULE4: clearing writes zero
  a_init_clear: assert property ((s_reg.st == S_INIT && bus_wr_o) |-> // RULE4
    bus_wdata_o == gq_ctrl_pkg::MASK_NONE && bus_addr_o == rmw.waddr)
    else $error("initial mask store not empty");
  // RULE13: matching read gives done
  a_done_match: assert property ((s_reg.st == S_POLL && bus_rd_o && bus_ack_i && // RULE13
    bus_rdata_i == s_reg.expect_word) |=> done_o && result_o == $past(bus_rdata_i) && cmd_ready_o)
    else $error("matching read not reported");
  // RULE16: pause after unchanged read
  a_poll_pause: assert property ((s_reg.st == S_POLL && bus_ack_i && // RULE16
    bus_rdata_i != s_reg.expect_word && s_reg.polls != LAST_POLL) |=> !bus_rd_o [*8])
    else $error("poll repeated without pause");
  // RULE20: empty marker stored
  a_empty_byte: assert property ((s_reg.st == S_REQ && bus_wr_o && // RULE20
    s_reg.op == gq_ctrl_pkg::OP_REQ_EMPTY) |-> bus_wdata_o[31:24] == gq_ctrl_pkg::FAVORED_EMPTY)
    else $error("empty request not 0xFF");
  // RULE17: descriptor word offsets
  a_desc_offset: assert property ((s_reg.st == S_DESC && bus_rd_o) |-> // RULE17
    bus_addr_o == desc_addr_i + {27'h0, s_reg.didx, 2'b00})
    else $error("descriptor read at wrong offset");
  // RULE18: machine access refused
  a_access_type: assert property ((s_reg.st == S_DESC && bus_ack_i && // RULE18
    s_reg.didx == gq_ctrl_pkg::DESC_WTYPE && bus_rdata_i != gq_ctrl_pkg::ACCESS_MEMORY)
    |=> s_reg.bad)
    else $error("non-memory access type accepted");

  c_enable_done: cover property (s_reg.st == S_POLL && s_reg.op == gq_ctrl_pkg::OP_CPU_ON ##1 done_o);
  c_poll_retry: cover property (s_reg.st == S_GAP ##[1:40] s_reg.st == S_POLL);
  c_timeout: cover property (error_o && error_code_o == gq_ctrl_pkg::ERR_TIMEOUT);
  c_byte_store: cover property (bus_wr_o && bus_be_o == gq_ctrl_pkg::BE_FAVORED && bus_ack_i);

endmodule : gq_ctrl

`default_nettype wire

// ---- verification/dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behavioural device: descriptor, mask words with lagging read-back, request word
module dev_model #(
  parameter logic [31:0] DESC = 32'h0,
  parameter logic [31:0] WB = 32'h0,
  parameter logic [31:0] RB = 32'h0,
  parameter logic [31:0] GW = 32'h0,
  parameter logic [31:0] GR = 32'h0,
  parameter logic [31:0] REQ = 32'h0,
  parameter logic [31:0] COUNT = 32'h0
) (
  input wire logic clock_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [3:0] bus_be_i,
  input wire logic [31:0] bus_wdata_i,
  output logic [31:0] bus_rdata_o,
  output logic bus_ack_o
);
  bit [31:0] mem [bit [31:0]];  // Sparse word store
  int lag = 0;                  // Extra cycles, after the first, before a write shows on the read side
  bit stuck = 1'b0;             // Read side never follows writes
  int bad = 0;                  // Misaligned accesses or writes to read side
  bit ipi = 1'b0;               // Request word raises a processor interrupt
  bit [23:0] src = 24'h0;       // External source register of the signalled processor
  int dly = 0;                  // Ack delay of the current transfer
  int wait_n = 0;               // Cycles waited so far
  int pend_n = 0;               // Countdown of the pending read-side copy
  bit [31:0] pend_a;            // Read-side address of the pending copy
  bit [31:0] pend_d;            // Data of the pending copy

  initial
  begin
    mem[DESC] = COUNT;
    mem[DESC + 4] = 32'h0;
    mem[DESC + 8] = WB;
    mem[DESC + 12] = 32'h0;
    mem[DESC + 16] = RB;
    bus_rdata_o = 32'h0;
    bus_ack_o = 1'b0;
  end

  // Answers one transfer at a time with 0..2 cycles of delay
  always @(posedge clock_i)
  begin
    // read side follows a write after the lag
    if (pend_n > 0)
    begin
      pend_n--;
      if (pend_n == 0 && !stuck)
        mem[pend_a] = pend_d;
    end
    bus_ack_o <= 1'b0;
    bus_rdata_o <= ~bus_rdata_o;
    if ((bus_rd_i || bus_wr_i) && !bus_ack_o)
    begin
      if (wait_n < dly)
        wait_n++;
      else
      begin
        wait_n = 0;
        dly = $urandom_range(2);
        bus_ack_o <= 1'b1;
        if (bus_addr_i[1:0] != 2'h0)
          bad++;
        if (bus_rd_i)
          bus_rdata_o <= mem[bus_addr_i];
        else
        begin
          // byte-enabled store into the addressed word
          for (int b = 0; b < 4; b++)
            if (bus_be_i[b])
              mem[bus_addr_i][8*b+:8] = bus_wdata_i[8*b+:8];
          // read side is never written by software
          if (bus_addr_i[31:12] == RB[31:12] || bus_addr_i[31:12] == GR[31:12])
            bad++;
          if (bus_addr_i[31:12] == WB[31:12] || bus_addr_i[31:12] == GW[31:12])
          begin
            pend_a = bus_addr_i + (RB - WB);
            pend_d = mem[bus_addr_i];
            pend_n = lag + 1;
          end
          // favored byte of all ones is an empty queue
          ipi = (mem[REQ][31:24] != 8'hFF);
          if (ipi)
            src = mem[REQ][23:0];
        end
      end
    end
  end
endmodule : dev_model

`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [31:0] DESC = 32'h00001000;
  localparam logic [31:0] WB = 32'h00002000;
  localparam logic [31:0] RB = 32'h00003000;
  localparam logic [31:0] GW = 32'h00004000;
  localparam logic [31:0] GR = 32'h00005000;
  localparam logic [31:0] REQ = 32'h00006000;
  // One expected completion
  typedef struct packed {logic cpu_op; logic err; logic [1:0] code; logic [31:0] res;} exp_s;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  gq_ctrl_pkg::op_e cmd_op_i = gq_ctrl_pkg::OP_CPU_ON;
  gq_ctrl_pkg::target_e cmd_target_i = gq_ctrl_pkg::TGT_AVAIL;
  logic [7:0] cmd_cpu_i = 8'h00;
  logic [31:0] cmd_data_i = 32'h0;
  logic cmd_ready_o, done_o, error_o, bus_rd_o, bus_wr_o, bus_ack_i;
  logic [1:0] error_code_o;
  logic [3:0] bus_be_o;
  logic [31:0] result_o, bus_addr_o, bus_wdata_o, bus_rdata_i, prev;
  exp_s q[$];
  exp_s e;
  int mismatches = 0;
  int compares = 0;
  logic [7:0] cpus [5] = '{8'h23, 8'h00, 8'h1F, 8'h20, 8'h27};  // Word and bit corners

  gq_ctrl #(.CPU_W(8), .MAX_POLLS(4)) dut_u (.clock_i(clock_i), .resetn_i(resetn_i),
    .desc_addr_i(DESC), .gq_wbase_i(GW), .gq_rbase_i(GR), .gq_req_addr_i(REQ),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_target_i(cmd_target_i),
    .cmd_cpu_i(cmd_cpu_i), .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
    .done_o(done_o), .error_o(error_o), .error_code_o(error_code_o), .result_o(result_o),
    .bus_addr_o(bus_addr_o), .bus_rd_o(bus_rd_o), .bus_wr_o(bus_wr_o), .bus_be_o(bus_be_o),
    .bus_wdata_o(bus_wdata_o), .bus_rdata_i(bus_rdata_i), .bus_ack_i(bus_ack_i));
  dev_model #(.DESC(DESC), .WB(WB), .RB(RB), .GW(GW), .GR(GR), .REQ(REQ), .COUNT(32'd40))
    dev_u (.clock_i(clock_i), .bus_addr_i(bus_addr_o), .bus_rd_i(bus_rd_o),
    .bus_wr_i(bus_wr_o), .bus_be_i(bus_be_o), .bus_wdata_i(bus_wdata_o),
    .bus_rdata_o(bus_rdata_i), .bus_ack_o(bus_ack_i));

  // Clock of 5 ns
  initial
    forever #2.5 clock_i = ~clock_i;

  // Counts and reports one comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  // Closing report
  task automatic print_verdict();
    $display("Mismatches %0d, compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Bounded wait on ready high (r=1) or on an empty queue (r=0)
  task automatic wait_for(input bit r);
    int n;
    n = 0;
    while ((r ? cmd_ready_o !== 1'b1 : q.size() != 0) && n < 2000)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n >= 2000)
    begin
      check(32'h1, 32'h0);
      print_verdict();
    end
  endtask : wait_for

  // Gives one command, optionally a stray request while busy, awaits its result
  task automatic issue(input gq_ctrl_pkg::op_e op, input gq_ctrl_pkg::target_e tg,
      input logic [7:0] cpu, input logic [31:0] data, input exp_s x, input bit stray);
    wait_for(1'b1);
    cmd_op_i = op;
    cmd_target_i = tg;
    cmd_cpu_i = cpu;
    cmd_data_i = data;
    cmd_valid_i = 1'b1;
    q.push_back(x);
    @(posedge clock_i);
    #1;
    cmd_valid_i = stray;
    cmd_op_i = gq_ctrl_pkg::OP_REQ_EMPTY;
    @(posedge clock_i);
    #1;
    cmd_valid_i = 1'b0;
    wait_for(1'b0);
  endtask : issue

  // Processor enable or disable with a random old word
  task automatic cpu_op(input gq_ctrl_pkg::op_e op, input gq_ctrl_pkg::target_e tg,
      input logic [7:0] cpu, input int lag, input bit stuck);
    logic [31:0] wa, old, nw;
    wa = (tg == gq_ctrl_pkg::TGT_AVAIL ? WB : GW) + {27'h0, cpu[7:5], 2'h0};
    old = $urandom();
    // A stuck read side must still differ from the merged word
    if (stuck)
      old[cpu[4:0]] = (op == gq_ctrl_pkg::OP_CPU_OFF);
    dev_u.mem[wa] = old;
    dev_u.mem[wa + (RB - WB)] = old;
    nw = (op == gq_ctrl_pkg::OP_CPU_ON) ? old | (32'h1 << cpu[4:0]) : old & ~(32'h1 << cpu[4:0]);
    dev_u.lag = lag;
    dev_u.stuck = stuck;
    e = stuck ? {1'b1, 1'b1, 2'h2, old} : {1'b1, 1'b0, 2'h0, nw};
    issue(op, tg, cpu, $urandom(), e, 1'b0);
    check(dev_u.mem[wa], nw);
    dev_u.stuck = 1'b0;
  endtask : cpu_op

  // Compares every completion with the oldest expectation
  always
  begin
    @(posedge clock_i);
    #2;
    if (done_o === 1'b1 || error_o === 1'b1)
    begin
      if (q.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        e = q.pop_front();
        check({30'h0, error_o, done_o}, {30'h0, e.err, ~e.err});
        check({30'h0, error_code_o}, {30'h0, e.code});
        if (e.cpu_op)
          check(result_o, e.res);
      end
    end
  end

  // ********
  // Main sequence
  // ********
  initial
  begin
    void'($urandom(76765));
    dev_u.mem[GW] = 32'hFFFFFFFF;
    dev_u.mem[GW + 4] = 32'hA5A5A5A5;
    repeat (6) @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    wait_for(1'b1);
    check(dev_u.mem[GW], gq_ctrl_pkg::MASK_NONE);
    check(dev_u.mem[GW + 4], gq_ctrl_pkg::MASK_NONE);
    foreach (cpus[i])
      cpu_op(gq_ctrl_pkg::OP_CPU_ON, gq_ctrl_pkg::TGT_AVAIL, cpus[i], 0, 0);
    repeat (12)
      cpu_op(gq_ctrl_pkg::op_e'($urandom_range(1)), gq_ctrl_pkg::target_e'($urandom_range(1)),
        8'($urandom_range(39)), $urandom_range(1) * 30, 0);
    cpu_op(gq_ctrl_pkg::OP_CPU_OFF, gq_ctrl_pkg::TGT_GLOBAL, 8'd33, 0, 1);
    issue(gq_ctrl_pkg::OP_CPU_ON, gq_ctrl_pkg::TGT_AVAIL, 8'd40, 32'h0, {1'b0, 1'b1, 2'h3, 32'h0}, 0);
    prev = $urandom();
    issue(gq_ctrl_pkg::OP_REQ_FULL, gq_ctrl_pkg::TGT_AVAIL, 8'h0, prev, 36'h0, 1);
    check(dev_u.mem[REQ], prev);
    issue(gq_ctrl_pkg::OP_REQ_BYTE, gq_ctrl_pkg::TGT_AVAIL, 8'h0, 32'h5C, 36'h0, 0);
    check(dev_u.mem[REQ], {8'h5C, prev[23:0]});
    check({31'h0, dev_u.ipi}, 32'h1);
    check({8'h0, dev_u.src}, {8'h0, prev[23:0]});
    issue(gq_ctrl_pkg::OP_REQ_EMPTY, gq_ctrl_pkg::TGT_AVAIL, 8'h0, 32'h0, 36'h0, 0);
    check(dev_u.mem[REQ], {8'hFF, prev[23:0]});
    check({31'h0, dev_u.ipi}, 32'h0);
    check(dev_u.bad, 32'h0);
    resetn_i = 1'b0;
    dev_u.mem[DESC + 4] = gq_ctrl_pkg::ACCESS_MACHINE;
    q.push_back({1'b0, 1'b1, 2'h1, 32'h0});
    @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    wait_for(1'b0);
    repeat (10) @(posedge clock_i);
    check({31'h0, cmd_ready_o}, 32'h0);
    print_verdict();
  end
endmodule : tb

`default_nettype wire
